// ---- fcc_pkg.sv ----
// package: register map, field layout, states and carrier types of the compression control block
package fcc_pkg;

   // register byte offsets
   localparam logic [15:0] FCC_OFS_CONTROL  = 16'h3208;
   localparam logic [15:0] FCC_OFS_COMMAND  = 16'h320c;
   localparam logic [15:0] FCC_OFS_STATUS   = 16'h3210;
   localparam logic [15:0] FCC_OFS_CONTROL2 = 16'h3214;

   // reset values
   localparam logic [31:0] FCC_RST_CONTROL  = 32'h0000_0000;
   localparam logic [31:0] FCC_RST_COMMAND  = 32'h0000_0000;
   localparam logic [31:0] FCC_RST_STATUS   = 32'h2000_0000;
   localparam logic [31:0] FCC_RST_CONTROL2 = 32'h0000_0000;

   // control fields; bits 13 and 4 are reserved and read as zero
   localparam int          FCC_CTL_ENABLE   = 31;
   localparam int          FCC_CTL_PERIODIC = 30;
   localparam int          FCC_CTL_INT_HI   = 29;
   localparam int          FCC_CTL_INT_LO   = 16;
   localparam int          FCC_CTL_ABORT    = 15;
   localparam int          FCC_CTL_UNCMP    = 14;
   localparam int          FCC_CTL_STR_HI   = 12;
   localparam int          FCC_CTL_STR_LO   = 5;
   localparam int          FCC_CTL_FEN_HI   = 3;
   localparam int          FCC_CTL_FEN_LO   = 0;
   localparam logic [31:0] FCC_CTL_MASK     = 32'hffff_dfef;

   // command, status and second control fields
   localparam int          FCC_CMD_TRIGGER  = 0;
   localparam int          FCC_ST_BUSY      = 31;
   localparam int          FCC_ST_DONE      = 30;
   localparam int          FCC_ST_MOD       = 29;
   localparam int          FCC_ST_LINE_HI   = 10;
   localparam int          FCC_C2_IMMED     = 4;
   localparam int          FCC_C2_LP_HI     = 3;
   localparam int          FCC_C2_LP_LO     = 2;

   // low-power idleness modes
   localparam logic [1:0]  FCC_LP_IGNORE    = 2'h0;
   localparam logic [1:0]  FCC_LP_REPORT    = 2'h1;
   localparam logic [1:0]  FCC_LP_PAIR      = 2'h2;

   // line pair tag codes
   localparam logic [1:0]  FCC_TAG_MODIFIED = 2'h0;
   localparam logic [1:0]  FCC_TAG_RAW      = 2'h1;
   localparam logic [1:0]  FCC_TAG_UNCMP    = 2'h2;
   localparam logic [1:0]  FCC_TAG_PACKED   = 2'h3;

   typedef enum logic [0:0] {
      FCC_IDLE = 1'b0,
      FCC_RUN  = 1'b1
   } fcc_state_t;

   // host register access
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } fcc_mmio_req_t;

   typedef struct packed {
      logic        rvalid;
      logic [31:0] rdata;
   } fcc_mmio_rsp_t;

   // from the compression datapath
   typedef struct packed {
      logic        line_valid;
      logic [10:0] line_num;
      logic [8:0]  line_len;
      logic        pass_done;
   } fcc_dp_in_t;

   // to the compression datapath
   typedef struct packed {
      logic        enable;
      logic [7:0]  stride;
      logic [3:0]  fence;
      logic        hold;
      logic        pass_start;
      logic        pass_abort;
      logic        store_raw;
      logic        tag_we;
      logic [9:0]  tag_pair;
      logic [1:0]  tag_val;
   } fcc_dp_out_t;

   // whole state of the block
   typedef struct packed {
      logic [31:0] ctl;
      logic        trig;
      logic [2:0]  ctl2;
      logic        en_act;
      logic [3:0]  fence_act;
      fcc_state_t  state;
      logic        compressed;
      logic        modified;
      logic [10:0] cur_line;
      logic [13:0] frames;
      logic        first_fail;
      logic        park;
      logic        idle;
      fcc_mmio_rsp_t rsp;
      fcc_dp_out_t dp;
   } fcc_st_t;

endpackage

// ---- fcc_frame_compress_ctrl.sv ----
// frame compression control: registers, pass sequencing, status and idleness reporting
`timescale 1ns/1ns
module fcc_frame_compress_ctrl
   import fcc_pkg::*;
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          reset,
   // host register access
   input  wire fcc_mmio_req_t mmio_req,
   output fcc_mmio_rsp_t      mmio_rsp,
   // display timing and memory traffic
   input  wire logic          vblank_start,
   input  wire logic          host_write,
   input  wire logic [3:0]    host_write_fence,
   input  wire logic          render_alloc,
   input  wire logic          power_state_entry_signal,
   // compression datapath
   input  wire fcc_dp_in_t    dp_in,
   output fcc_dp_out_t        dp_out,
   // self-refresh idleness
   output logic               idle_valid,
   output logic               idle
);

   fcc_st_t s_r;
   fcc_st_t s_nxt;

   logic        periodic;
   logic        double_buf;
   logic [1:0]  lp_mode;
   logic [13:0] interval;
   logic [7:0]  stride;
   logic [13:0] frames_inc;
   logic        hit;
   logic        start;
   logic        fits;
   logic [8:0]  stride_units;
   logic [31:0] rd_word;

   always_comb begin
      periodic     = s_r.ctl[FCC_CTL_PERIODIC];
      double_buf   = ~s_r.ctl2[FCC_C2_IMMED - FCC_C2_LP_LO];
      lp_mode      = s_r.ctl2[FCC_C2_LP_HI - FCC_C2_LP_LO:0];
      interval     = s_r.ctl[FCC_CTL_INT_HI:FCC_CTL_INT_LO];
      stride       = s_r.ctl[FCC_CTL_STR_HI:FCC_CTL_STR_LO];
      // the fence comparison only sees writes through the active fence
      hit          = (host_write && (host_write_fence == s_r.fence_act)) || render_alloc;
      // saturate so a long wait never wraps back below the interval
      frames_inc   = (&s_r.frames) ? s_r.frames : s_r.frames + 14'h0001;
      stride_units = {1'b0, stride} + 9'h001;
      fits         = (dp_in.line_len <= stride_units);
      // a pass only ever starts on a vertical blank edge
      start        = vblank_start && s_r.ctl[FCC_CTL_ENABLE] &&
                     (periodic ? (frames_inc >= interval) : s_r.trig);

      rd_word = 32'h0000_0000;
      unique case (mmio_req.addr)
         FCC_OFS_CONTROL:  rd_word = s_r.ctl;
         FCC_OFS_COMMAND:  rd_word[FCC_CMD_TRIGGER] = s_r.trig && !periodic;
         FCC_OFS_STATUS: begin
            rd_word[FCC_ST_BUSY]         = (s_r.state == FCC_RUN);
            rd_word[FCC_ST_DONE]         = s_r.compressed;
            rd_word[FCC_ST_MOD]          = s_r.modified;
            rd_word[FCC_ST_LINE_HI:0]    = s_r.cur_line;
         end
         FCC_OFS_CONTROL2: rd_word[FCC_C2_IMMED:FCC_C2_LP_LO] = s_r.ctl2;
         default:          rd_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      s_nxt               = s_r;
      s_nxt.rsp.rvalid    = mmio_req.rd;
      s_nxt.dp.pass_start = 1'b0;
      s_nxt.dp.pass_abort = 1'b0;
      s_nxt.dp.tag_we     = 1'b0;
      s_nxt.dp.store_raw  = 1'b0;
      if (mmio_req.rd) begin
         s_nxt.rsp.rdata = rd_word;
      end

      // update point at vertical blank
      if (vblank_start) begin
         s_nxt.en_act = s_r.ctl[FCC_CTL_ENABLE];
         s_nxt.frames = frames_inc;
         if (double_buf) begin
            s_nxt.fence_act = s_r.ctl[FCC_CTL_FEN_HI:FCC_CTL_FEN_LO];
         end
      end

      unique case (s_r.state)
         FCC_IDLE: begin
            if (start) begin
               s_nxt.state         = FCC_RUN;
               s_nxt.dp.pass_start = 1'b1;
               s_nxt.compressed    = 1'b0;
               s_nxt.modified      = 1'b0;
               s_nxt.cur_line      = 11'h000;
               s_nxt.frames        = 14'h0000;
               s_nxt.first_fail    = 1'b0;
            end
         end
         FCC_RUN: begin
            if (dp_in.line_valid) begin
               s_nxt.cur_line     = dp_in.line_num;
               s_nxt.dp.store_raw = !fits;
               if (!dp_in.line_num[0]) begin
                  s_nxt.first_fail = !fits;
               end else begin
                  s_nxt.dp.tag_we   = 1'b1;
                  s_nxt.dp.tag_pair = dp_in.line_num[10:1];
                  if (fits && !s_r.first_fail) begin
                     s_nxt.dp.tag_val = FCC_TAG_PACKED;
                  end else if (s_r.ctl[FCC_CTL_UNCMP]) begin
                     s_nxt.dp.tag_val = FCC_TAG_UNCMP;
                  end else begin
                     s_nxt.dp.tag_val = FCC_TAG_RAW;
                  end
               end
            end
            if ((s_r.ctl[FCC_CTL_ABORT] && hit) ||
                (vblank_start && !s_r.ctl[FCC_CTL_ENABLE])) begin
               // abandoned passes leave compressed clear
               s_nxt.state         = FCC_IDLE;
               s_nxt.dp.pass_abort = 1'b1;
               s_nxt.trig          = 1'b0;
            end else if (dp_in.pass_done) begin
               s_nxt.state      = FCC_IDLE;
               s_nxt.compressed = 1'b1;
               s_nxt.trig       = 1'b0;
            end
         end
      endcase

      // register writes come after hardware clears so a new trigger is kept
      if (mmio_req.wr) begin
         unique case (mmio_req.addr)
            FCC_OFS_CONTROL:  s_nxt.ctl = mmio_req.wdata & FCC_CTL_MASK;
            FCC_OFS_COMMAND: begin
               if (!periodic) begin
                  s_nxt.trig = mmio_req.wdata[FCC_CMD_TRIGGER];
               end
            end
            FCC_OFS_STATUS: begin
               // test mode writes; software checks the pass is idle first
               s_nxt.compressed = mmio_req.wdata[FCC_ST_DONE];
               s_nxt.modified   = mmio_req.wdata[FCC_ST_MOD];
            end
            FCC_OFS_CONTROL2: s_nxt.ctl2 = mmio_req.wdata[FCC_C2_IMMED:FCC_C2_LP_LO];
            default:          s_nxt.ctl2 = s_nxt.ctl2;
         endcase
      end

      if (!s_nxt.ctl2[FCC_C2_IMMED - FCC_C2_LP_LO]) begin
         s_nxt.fence_act = s_nxt.fence_act;
      end else begin
         s_nxt.fence_act = s_nxt.ctl[FCC_CTL_FEN_HI:FCC_CTL_FEN_LO];
      end

      // a hit in the same cycle as a clear still counts
      if (hit) begin
         s_nxt.modified = 1'b1;
      end

      // park only at a pair boundary so a pair is never left half done
      if (!power_state_entry_signal) begin
         s_nxt.park = 1'b0;
      end else if ((s_r.state == FCC_IDLE) || (dp_in.line_valid && dp_in.line_num[0])) begin
         s_nxt.park = 1'b1;
      end

      unique case (lp_mode)
         FCC_LP_REPORT: s_nxt.idle = (s_nxt.state == FCC_IDLE);
         FCC_LP_PAIR:   s_nxt.idle = (s_nxt.state == FCC_IDLE) || s_nxt.park;
         default:       s_nxt.idle = 1'b0;
      endcase

      s_nxt.dp.enable = s_nxt.en_act;
      s_nxt.dp.stride = s_nxt.ctl[FCC_CTL_STR_HI:FCC_CTL_STR_LO];
      s_nxt.dp.fence  = s_nxt.fence_act;
      // judge hold by the field being registered so it never outlives a mode change
      s_nxt.dp.hold   = s_nxt.park && (s_nxt.ctl2[FCC_C2_LP_HI - FCC_C2_LP_LO:0] == FCC_LP_PAIR);
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_r            <= '0;
         s_r.ctl        <= FCC_RST_CONTROL;
         s_r.trig       <= FCC_RST_COMMAND[FCC_CMD_TRIGGER];
         s_r.ctl2       <= FCC_RST_CONTROL2[FCC_C2_IMMED:FCC_C2_LP_LO];
         s_r.state      <= FCC_IDLE;
         s_r.compressed <= FCC_RST_STATUS[FCC_ST_DONE];
         s_r.modified   <= FCC_RST_STATUS[FCC_ST_MOD];
      end else begin
         s_r <= s_nxt;
      end
   end

   assign mmio_rsp   = s_r.rsp;
   assign dp_out     = s_r.dp;
   assign idle       = s_r.idle;
   assign idle_valid = (s_r.ctl2[FCC_C2_LP_HI - FCC_C2_LP_LO:0] == FCC_LP_REPORT) ||
                       (s_r.ctl2[FCC_C2_LP_HI - FCC_C2_LP_LO:0] == FCC_LP_PAIR);

endmodule

// ---- fcc_frame_compress_ctrl_chk.sv ----
// assertion checker for the frame compression control block
`timescale 1ns/1ns
module fcc_frame_compress_ctrl_chk
   import fcc_pkg::*;
(
   // clock and reset
   input wire logic          mclk,
   input wire logic          reset,
   // watched ports
   input wire fcc_mmio_req_t mmio_req,
   input wire fcc_mmio_rsp_t mmio_rsp,
   input wire logic          vblank_start,
   input wire logic          host_write,
   input wire logic [3:0]    host_write_fence,
   input wire logic          render_alloc,
   input wire logic          power_state_entry_signal,
   input wire fcc_dp_in_t    dp_in,
   input wire fcc_dp_out_t   dp_out,
   input wire logic          idle_valid,
   input wire logic          idle
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   property p_en_hold; !vblank_start |=> $stable(dp_out.enable); endproperty
   a_en_hold: assert property (p_en_hold) else $error("enable moved off vblank");
   property p_start_vb; dp_out.pass_start |-> $past(vblank_start); endproperty
   a_start_vb: assert property (p_start_vb) else $error("pass began off vblank");
   property p_raw;
      dp_in.line_valid && (dp_in.line_len > ({1'b0, dp_out.stride} + 9'h1)) |=> dp_out.store_raw;
   endproperty
   a_raw: assert property (p_raw) else $error("oversized line not kept raw");
   property p_tag;
      dp_out.tag_we |-> $past(dp_in.line_valid) && $past(dp_in.line_num[0])
         && dp_out.tag_pair == 10'($past(dp_in.line_num) >> 1);
   endproperty
   a_tag: assert property (p_tag) else $error("tag write without odd line");
   property p_hold; dp_out.hold |-> idle_valid; endproperty
   a_hold: assert property (p_hold) else $error("parked while idleness ignored");
   property p_abort;
      dp_out.pass_abort |-> $past(host_write) || $past(render_alloc) || $past(vblank_start);
   endproperty
   a_abort: assert property (p_abort) else $error("abort without cause");
   property p_rd; mmio_req.rd |=> mmio_rsp.rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_no_rd; !mmio_req.rd |=> !mmio_rsp.rvalid; endproperty
   a_no_rd: assert property (p_no_rd) else $error("answer without read");
   property p_start_pulse; dp_out.pass_start |=> !dp_out.pass_start; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start held");
endmodule

bind fcc_frame_compress_ctrl fcc_frame_compress_ctrl_chk u_chk (.mclk(mclk), .reset(reset),
   .mmio_req(mmio_req), .mmio_rsp(mmio_rsp), .vblank_start(vblank_start),
   .host_write(host_write), .host_write_fence(host_write_fence), .render_alloc(render_alloc),
   .power_state_entry_signal(power_state_entry_signal), .dp_in(dp_in), .dp_out(dp_out),
   .idle_valid(idle_valid), .idle(idle));

// ---- tb_fcc_frame_compress_ctrl.sv ----
// self-checking bench for the frame compression control block
`timescale 1ns/1ns
module tb_fcc_frame_compress_ctrl;
   import fcc_pkg::*;
   logic          mclk = 1'b0;
   logic          reset = 1'b1;
   fcc_mmio_req_t req = '0;
   fcc_mmio_rsp_t rsp;
   logic          vb = 1'b0;
   logic          hw = 1'b0;
   logic [3:0]    hwf = 4'h0;
   logic          ra = 1'b0;
   logic          pse = 1'b0;
   fcc_dp_in_t    din = '0;
   fcc_dp_out_t   dout;
   logic          idle_valid;
   logic          idle;
   int            err_count = 0;
   int            checks = 0;
   int            cyc_count = 0;

   always #5 mclk = ~mclk;

   fcc_frame_compress_ctrl u_fcc_frame_compress_ctrl (.mclk(mclk), .reset(reset),
      .mmio_req(req), .mmio_rsp(rsp), .vblank_start(vb), .host_write(hw),
      .host_write_fence(hwf), .render_alloc(ra), .power_state_entry_signal(pse),
      .dp_in(din), .dp_out(dout), .idle_valid(idle_valid), .idle(idle));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // generous ceiling; the whole sequence needs about a hundred cycles
   always @(posedge mclk) begin
      cyc_count++;
      if (cyc_count == 3000) begin
         err_count++;
         $display("BAD %0t timeout", $time);
         complete_run();
      end
   end

   // inputs move 1 ns after the edge so the design samples them cleanly
   task automatic cyc(input int n = 1);
      repeat (n) begin
         @(posedge mclk);
         #1;
      end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      cyc();
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      cyc();
      req.wr = 1'b0;
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
      cyc();
      req.rd = 1'b1;
      req.addr = a;
      cyc();
      req.rd = 1'b0;
      chk(rsp.rvalid, 1);
      chk(rsp.rdata, exp);
   endtask
   task automatic vbl;
      cyc();
      vb = 1'b1;
      cyc();
      vb = 1'b0;
   endtask
   task automatic line(input logic [10:0] n, input logic [8:0] l);
      cyc();
      din.line_valid = 1'b1;
      din.line_num = n;
      din.line_len = l;
      cyc();
      din.line_valid = 1'b0;
   endtask
   task automatic hit(input logic [3:0] f, input logic alloc);
      cyc();
      hwf = f;
      hw = ~alloc;
      ra = alloc;
      cyc();
      hw = 1'b0;
      ra = 1'b0;
   endtask

   task automatic t_reset;
      rdchk(FCC_OFS_STATUS, FCC_RST_STATUS);
      rdchk(FCC_OFS_CONTROL, FCC_RST_CONTROL);
      rdchk(FCC_OFS_COMMAND, FCC_RST_COMMAND);
      rdchk(FCC_OFS_CONTROL2, FCC_RST_CONTROL2);
      rdchk(16'h3218, 32'h0);
      $display("t_reset done");
   endtask

   task automatic t_single;
      wr(FCC_OFS_CONTROL, 32'h8001_0043);
      wr(FCC_OFS_COMMAND, 32'h1);
      rdchk(FCC_OFS_COMMAND, 32'h1);
      chk(dout.enable, 0);
      vbl();
      chk(dout.pass_start, 1);
      chk(dout.enable, 1);
      chk(dout.stride, 32'h2);
      chk(dout.fence, 32'h3);
      rdchk(FCC_OFS_STATUS, 32'h8000_0000);
      line(11'h0, 9'h2);
      line(11'h1, 9'h4);
      chk(dout.store_raw, 1);
      chk({dout.tag_we, dout.tag_pair, dout.tag_val}, {1'b1, 10'h0, FCC_TAG_RAW});
      cyc();
      din.pass_done = 1'b1;
      cyc();
      din.pass_done = 1'b0;
      rdchk(FCC_OFS_STATUS, 32'h4000_0001);
      rdchk(FCC_OFS_COMMAND, 32'h0);
      // a write outside the active fence must not mark the buffer
      hit(4'h5, 1'b0);
      rdchk(FCC_OFS_STATUS, 32'h4000_0001);
      hit(4'h3, 1'b0);
      rdchk(FCC_OFS_STATUS, 32'h6000_0001);
      $display("t_single done");
   endtask

   task automatic t_periodic;
      // disable first and confirm idle before the mode changes
      wr(FCC_OFS_CONTROL, 32'h0001_0043);
      rdchk(FCC_OFS_STATUS, 32'h6000_0001);
      wr(FCC_OFS_CONTROL, 32'hc002_c043);
      wr(FCC_OFS_COMMAND, 32'h1);
      rdchk(FCC_OFS_COMMAND, 32'h0);
      vbl();
      chk(dout.pass_start, 0);
      vbl();
      chk(dout.pass_start, 1);
      rdchk(FCC_OFS_STATUS, 32'h8000_0000);
      line(11'h2, 9'h1);
      line(11'h3, 9'h9);
      chk({dout.tag_we, dout.tag_pair, dout.tag_val}, {1'b1, 10'h1, FCC_TAG_UNCMP});
      hit(4'h0, 1'b1);
      chk(dout.pass_abort, 1);
      rdchk(FCC_OFS_STATUS, 32'h2000_0003);
      $display("t_periodic done");
   endtask

   task automatic t_fence_lp;
      wr(FCC_OFS_CONTROL2, 32'h10);
      rdchk(FCC_OFS_CONTROL2, 32'h10);
      wr(FCC_OFS_CONTROL, 32'h4002_c043);
      wr(FCC_OFS_CONTROL, 32'h7);
      cyc(2);
      chk(dout.fence, 32'h7);
      chk(dout.enable, 1);
      wr(FCC_OFS_CONTROL2, 32'h0);
      wr(FCC_OFS_CONTROL, 32'h9);
      cyc(2);
      chk(dout.fence, 32'h7);
      vbl();
      chk(dout.fence, 32'h9);
      chk({dout.enable, dout.pass_start}, 0);
      // test mode status write, only after the busy bit reads clear
      rdchk(FCC_OFS_STATUS, 32'h2000_0003);
      wr(FCC_OFS_STATUS, 32'h4000_0000);
      rdchk(FCC_OFS_STATUS, 32'h4000_0003);
      pse = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(FCC_OFS_CONTROL2, 32'(i) << 2);
         chk(idle_valid, 32'(i == 1 || i == 2));
         cyc();
         chk(idle, 32'(i == 1 || i == 2));
         chk(dout.hold, 32'(i == 2));
      end
      $display("t_fence_lp done");
   endtask

   initial begin
      repeat (6) @(posedge mclk);
      #1;
      reset = 1'b0;
      t_reset();
      t_single();
      t_periodic();
      t_fence_lp();
      complete_run();
   end
endmodule
